// File: design/dcrb_bank.sv
// Serial-port configuration register bank with soft reset and boot status
`timescale 1ns/1ps
`default_nettype none
`include "dcrb_params.svh"
// Contract
// - Writing 1 to serial control bit 7 puts the device in soft reset.
// - Soft reset holds until host writes 0 to both the reset bit 7 and its mirror bit 0.
// - During soft reset all configuration registers hold their defaults.
// - Bit 6 selects bit order: 0 MSB first, 1 LSB first.
// - Bit 5 steps multibyte address: 0 downward, 1 upward.
// - Bit 4 low: data pin bidirectional, serial output pin off.
// - Bit 4 high: data pin input only, serial output drives reads when serial output pin enable is set.
// - Bits 3..0 mirror bits 4..7 and always hold the same values.
// - Clock divider register holds 3-bit and 2-bit dividers, default 0x02.
// - Strobe register has 2-bit load field, upper bits zero, default 0x00.
// - Load field rising from zero copies coefficient bytes to active filter.
// - Checksum register returns checksum computed at last boot load.
// - Status bit 0 reads 1 after good boot, 0 after timeout.
module dcrb_bank #(
  parameter logic [3:0] REV_ID = `DCRB_REV_ID, // Arbitrary value
  parameter int N_COEF = `DCRB_N_COEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csn,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic boot_busy,
  input wire logic boot_done,
  input wire logic boot_timeout,
  input wire logic [7:0] boot_sum,
  input wire logic [7:0] boot_sum_stored,
  output logic soft_reset,
  output logic [2:0] input_clock_divider,
  output logic [1:0] ref_clock_divider,
  output logic [7:0] analog_pin_cfg,
  output logic [7:0] sync_cfg,
  output logic [7:0] mixer_cfg,
  output logic serial_out_pin_enable,
  output logic core_reset,
  output logic coef_load_fire,
  output logic [N_COEF*8-1:0] active_coef
);
  logic [2:0] sclk_s_reg, csn_s_reg, din_s_reg;
  logic sclk_f_reg, csn_f_reg, din_f_reg, sclk_p_reg;
  dcrb_pkg::dcrb_phase_t ph_reg;
  logic [3:0] cnt_reg;
  logic [15:0] sr_reg;
  logic rw_reg;
  logic [`DCRB_ADDR_W-1:0] addr_reg;
  logic dout_reg;
  logic [3:0] spc_reg;
  logic [7:0] strobe_reg, apin_reg, sync_reg, mix_reg, clk_reg, dpin_reg, core_reg;
  logic [7:0] coef_reg [N_COEF];
  logic [7:0] sum_reg;
  logic [2:0] stat_reg;
  logic strobe_p_reg;
  logic [N_COEF*8-1:0] act_reg;

  // Pin filtering: change accepted once stages two and three agree
  always_ff @(posedge clock)
  begin
    sclk_s_reg <= {sclk_s_reg[1:0], sclk};
    csn_s_reg <= {csn_s_reg[1:0], csn};
    din_s_reg <= {din_s_reg[1:0], sdio_i};
    if (!rstn)
    begin
      sclk_f_reg <= 1'b0;
      csn_f_reg <= 1'b1;
      din_f_reg <= 1'b0;
      sclk_p_reg <= 1'b0;
    end
    else
    begin
      if (sclk_s_reg[1] == sclk_s_reg[2]) sclk_f_reg <= sclk_s_reg[2];
      if (csn_s_reg[1] == csn_s_reg[2]) csn_f_reg <= csn_s_reg[2];
      if (din_s_reg[1] == din_s_reg[2]) din_f_reg <= din_s_reg[2];
      sclk_p_reg <= sclk_f_reg;
    end
  end

  wire active = !csn_f_reg && !boot_busy;
  wire rise = active && sclk_f_reg && !sclk_p_reg;
  wire fall = active && !sclk_f_reg && sclk_p_reg;
  wire lsb_first = spc_reg[2];
  wire addr_up = spc_reg[1];
  wire four_wire = spc_reg[0];
  assign soft_reset = spc_reg[3];

  // Bit order of the shifter
  // order select
  wire [15:0] sr_next = lsb_first ? {din_f_reg, sr_reg[15:1]} : {sr_reg[14:0], din_f_reg};
  wire [7:0] wr_byte = lsb_first ? sr_next[15:8] : sr_next[7:0];
  wire instr_end = rise && ph_reg == dcrb_pkg::PH_INSTR && cnt_reg == `DCRB_INSTR_LAST;
  wire byte_end = rise && ph_reg == dcrb_pkg::PH_DATA && cnt_reg == `DCRB_BYTE_LAST;
  wire wr_fire = byte_end && !rw_reg;

  // Frame sequencer
  always_ff @(posedge clock)
  begin
    if (!rstn || !active)
    begin
      ph_reg <= dcrb_pkg::PH_IDLE;
      cnt_reg <= 4'h0;
      sr_reg <= 16'h0000;
      rw_reg <= 1'b0;
      addr_reg <= '0;
    end
    else
    begin
      case (ph_reg)
        dcrb_pkg::PH_IDLE:
        begin
          ph_reg <= dcrb_pkg::PH_INSTR;
          cnt_reg <= 4'h0;
        end
        dcrb_pkg::PH_INSTR:
          if (rise)
          begin
            sr_reg <= sr_next;
            cnt_reg <= instr_end ? 4'h0 : cnt_reg + 4'h1;
            if (instr_end)
            begin
              ph_reg <= dcrb_pkg::PH_DATA;
              rw_reg <= sr_next[15];
              addr_reg <= sr_next[14:0];
            end
          end
        dcrb_pkg::PH_DATA:
          if (rise)
          begin
            sr_reg <= sr_next;
            cnt_reg <= byte_end ? 4'h0 : cnt_reg + 4'h1;
            if (byte_end) addr_reg <= addr_up ? addr_reg + 15'h0001 : addr_reg - 15'h0001;
          end
        default: ph_reg <= dcrb_pkg::PH_IDLE;
      endcase
    end
  end

  // Write decode
  wire we_spc = wr_fire && addr_reg == `DCRB_OFF_SPC;
  wire we_strobe = wr_fire && addr_reg == `DCRB_OFF_STROBE;
  wire we_coef = wr_fire && addr_reg >= `DCRB_OFF_COEF_LO && addr_reg <= `DCRB_OFF_COEF_HI;
  wire we_apin = wr_fire && addr_reg == `DCRB_OFF_APIN;
  wire we_sync = wr_fire && addr_reg == `DCRB_OFF_SYNC;
  wire we_mix = wr_fire && addr_reg == `DCRB_OFF_MIX;
  wire we_clk = wr_fire && addr_reg == `DCRB_OFF_CLK;
  wire we_dpin = wr_fire && addr_reg == `DCRB_OFF_DPIN;
  wire we_core = wr_fire && addr_reg == `DCRB_OFF_CORE;
  wire [4:0] coef_idx = 5'(addr_reg - `DCRB_OFF_COEF_LO);
  // Either nibble of a mirror pair sets the stored bit
  // mirror merge
  wire [3:0] spc_wr = wr_byte[7:4] | {wr_byte[0], wr_byte[1], wr_byte[2], wr_byte[3]};
  wire [3:0] spc_next = we_spc ? (spc_wr[3] ? `DCRB_SPC_RST : spc_wr) : spc_reg;
  wire hold_def = spc_next[3];

  always_ff @(posedge clock)
  begin
    if (!rstn)
      spc_reg <= `DCRB_DEF_SPC;
    else
      spc_reg <= spc_next;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn || hold_def)
    begin
      strobe_reg <= `DCRB_DEF_STROBE;
      apin_reg <= `DCRB_DEF_APIN;
      sync_reg <= `DCRB_DEF_SYNC;
      mix_reg <= `DCRB_DEF_MIX;
      clk_reg <= `DCRB_DEF_CLK;
      dpin_reg <= `DCRB_DEF_DPIN;
      core_reg <= `DCRB_DEF_CORE;
    end
    else
    begin
      if (we_strobe) strobe_reg <= wr_byte & `DCRB_MSK_STROBE;
      if (we_apin) apin_reg <= wr_byte & `DCRB_MSK_APIN;
      if (we_sync) sync_reg <= wr_byte & `DCRB_MSK_SYNC;
      if (we_mix) mix_reg <= wr_byte & `DCRB_MSK_MIX;
      if (we_clk) clk_reg <= wr_byte & `DCRB_MSK_CLK;
      if (we_dpin) dpin_reg <= wr_byte & `DCRB_MSK_ONE;
      if (we_core) core_reg <= wr_byte & `DCRB_MSK_ONE;
    end
  end

  wire [N_COEF*8-1:0] coef_def = `DCRB_DEF_COEF;
  logic [N_COEF*8-1:0] coef_flat;
  genvar gi;
  generate
    for (gi = 0; gi < N_COEF; gi++)
    begin : g_coef
      assign coef_flat[(N_COEF-gi)*8-1 -: 8] = coef_reg[gi];
      always_ff @(posedge clock)
      begin
        if (!rstn || hold_def)
          coef_reg[gi] <= coef_def[(N_COEF-gi)*8-1 -: 8];
        else if (we_coef && coef_idx == 5'(gi))
          coef_reg[gi] <= wr_byte;
      end
    end
  endgenerate

  wire strobe_set = strobe_reg[1:0] != 2'b00;
  assign coef_load_fire = strobe_set && !strobe_p_reg;
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      strobe_p_reg <= 1'b0;
      act_reg <= `DCRB_DEF_COEF;
    end
    else
    begin
      strobe_p_reg <= strobe_set;
      if (coef_load_fire) act_reg <= coef_flat;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sum_reg <= 8'h00;
      stat_reg <= 3'h0;
    end
    else if (boot_done)
    begin
      sum_reg <= boot_sum;
      stat_reg <= {boot_timeout || boot_sum != boot_sum_stored,
                   !boot_timeout && boot_sum == boot_sum_stored, !boot_timeout};
    end
  end

  // Read decode; unmapped addresses read zero
  // mirror readback
  wire [7:0] spc_rd = {spc_reg, spc_reg[0], spc_reg[1], spc_reg[2], spc_reg[3]};
  wire [7:0] rd_byte =
    addr_reg == `DCRB_OFF_SPC ? spc_rd :
    addr_reg == `DCRB_OFF_REV ? {4'h0, REV_ID} :
    addr_reg == `DCRB_OFF_STROBE ? strobe_reg :
    we_coef || (addr_reg >= `DCRB_OFF_COEF_LO && addr_reg <= `DCRB_OFF_COEF_HI) ? coef_reg[coef_idx] :
    addr_reg == `DCRB_OFF_APIN ? apin_reg :
    addr_reg == `DCRB_OFF_SYNC ? sync_reg :
    addr_reg == `DCRB_OFF_MIX ? mix_reg :
    addr_reg == `DCRB_OFF_CLK ? clk_reg :
    addr_reg == `DCRB_OFF_DPIN ? dpin_reg :
    addr_reg == `DCRB_OFF_CORE ? core_reg :
    addr_reg == `DCRB_OFF_SUM ? sum_reg :
    addr_reg == `DCRB_OFF_STAT ? {5'h00, stat_reg} : 8'h00;

  // Read data launched at falling serial clock
  wire [2:0] bit_sel = lsb_first ? cnt_reg[2:0] : 3'h7 - cnt_reg[2:0];
  always_ff @(posedge clock)
  begin
    if (!rstn)
      dout_reg <= 1'b0;
    else if (fall && ph_reg == dcrb_pkg::PH_DATA && rw_reg)
      dout_reg <= rd_byte[bit_sel];
  end

  wire reading = active && ph_reg == dcrb_pkg::PH_DATA && rw_reg;
  assign sdio_o = dout_reg;
  assign serial_data_out = dout_reg;
  assign sdio_oe = reading && !four_wire;
  assign serial_data_out_oe = reading && four_wire && dpin_reg[0];

  assign input_clock_divider = clk_reg[4:2];
  assign ref_clock_divider = clk_reg[1:0];
  assign analog_pin_cfg = apin_reg;
  assign sync_cfg = sync_reg;
  assign mixer_cfg = mix_reg;
  assign serial_out_pin_enable = dpin_reg[0];
  assign core_reset = core_reg[0];
  assign active_coef = act_reg;

  sequence s_reset_write;
    we_spc && spc_wr[3];
  endsequence
  sequence s_no_release;
    !(we_spc && !spc_wr[3]);
  endsequence
  chk_reset_entry_hold: assert property (@(posedge clock) disable iff (!rstn)
    s_reset_write |=> soft_reset && spc_reg == `DCRB_SPC_RST) else $error("soft reset not entered");
  chk_reset_no_exit: assert property (@(posedge clock) disable iff (!rstn)
    (soft_reset and s_no_release) |=> soft_reset) else $error("soft reset left without write");
  chk_default_restore: assert property (@(posedge clock) disable iff (!rstn)
    soft_reset |-> sync_reg == `DCRB_DEF_SYNC && mix_reg == `DCRB_DEF_MIX && clk_reg == `DCRB_DEF_CLK)
    else $error("defaults not held in soft reset");
  chk_mirror_pair_match: assert property (@(posedge clock) disable iff (!rstn)
    addr_reg == `DCRB_OFF_SPC |-> rd_byte[3:0] == {rd_byte[4], rd_byte[5], rd_byte[6], rd_byte[7]})
    else $error("mirror mismatch");
  chk_addr_step_dir: assert property (@(posedge clock) disable iff (!rstn)
    byte_end && active |=> addr_reg == ($past(addr_up) ? $past(addr_reg) + 15'h0001 : $past(addr_reg) - 15'h0001))
    else $error("address step wrong");
  chk_pin_mode_sel: assert property (@(posedge clock) disable iff (!rstn)
    !(sdio_oe && four_wire) && !(serial_data_out_oe && !four_wire)) else $error("pin mode wrong");
  chk_coef_load_copy: assert property (@(posedge clock) disable iff (!rstn)
    coef_load_fire |=> active_coef == $past(coef_flat)) else $error("coefficients not loaded");
  chk_boot_status_set: assert property (@(posedge clock) disable iff (!rstn)
    boot_done |=> stat_reg[0] == !$past(boot_timeout) && stat_reg[1] != stat_reg[2] && sum_reg == $past(boot_sum))
    else $error("boot status wrong");
  chk_ro_write_ignore: assert property (@(posedge clock) disable iff (!rstn)
    wr_fire && addr_reg == `DCRB_OFF_SUM && !boot_done |=> $stable(sum_reg)) else $error("read-only written");
  chk_strobe_upper_zero: assert property (@(posedge clock) disable iff (!rstn)
    strobe_reg[7:2] == 6'h00 && clk_reg[7:5] == 3'h0) else $error("don't-care bits set");
endmodule
`default_nettype wire

// File: design/dcrb_params.svh
// Register map, field layout, defaults and counts for the configuration bank
`ifndef DCRB_PARAMS_SVH
`define DCRB_PARAMS_SVH
`define DCRB_ADDR_W 15
`define DCRB_OFF_SPC 15'h0000
`define DCRB_OFF_REV 15'h0006
`define DCRB_OFF_STROBE 15'h0010
`define DCRB_OFF_COEF_LO 15'h0011
`define DCRB_OFF_COEF_HI 15'h0027
`define DCRB_OFF_APIN 15'h0028
`define DCRB_OFF_SYNC 15'h0029
`define DCRB_OFF_MIX 15'h002a
`define DCRB_OFF_CLK 15'h002b
`define DCRB_OFF_DPIN 15'h002c
`define DCRB_OFF_CORE 15'h002d
`define DCRB_OFF_SUM 15'h002e
`define DCRB_OFF_STAT 15'h002f
`define DCRB_N_COEF 23
`define DCRB_BIT_RST 7
`define DCRB_BIT_LSB 6
`define DCRB_BIT_INC 5
`define DCRB_BIT_4W 4
`define DCRB_MSK_STROBE 8'h03
`define DCRB_MSK_APIN 8'h03
`define DCRB_MSK_SYNC 8'h3f
`define DCRB_MSK_MIX 8'h5f
`define DCRB_MSK_CLK 8'h1f
`define DCRB_MSK_ONE 8'h01
`define DCRB_DEF_SPC 4'h0
`define DCRB_SPC_RST 4'h8
`define DCRB_DEF_STROBE 8'h00
`define DCRB_DEF_APIN 8'h00
`define DCRB_DEF_SYNC 8'h2d
`define DCRB_DEF_MIX 8'h18
`define DCRB_DEF_CLK 8'h02
`define DCRB_DEF_DPIN 8'h01
`define DCRB_DEF_CORE 8'h00
`define DCRB_DEF_COEF 184'h000f1dd7c00fc00f1d977e88c00fc00f0f0060_00000000
`define DCRB_INSTR_LAST 4'hf
`define DCRB_BYTE_LAST 4'h7
`define DCRB_REV_ID 4'h3
`endif

// File: design/dcrb_pkg.sv
// Types shared by the configuration bank
package dcrb_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA = 2'b10
  } dcrb_phase_t;
endpackage

// File: sim/dcrb_host.sv
// Serial host model for the configuration bank pins
`timescale 1ns/1ps
`default_nettype none
module dcrb_host (
  input wire logic clock,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  output logic sclk,
  output logic csn,
  output logic sdio_i
);
  logic hbit = 1'b0;
  logic hdrv = 1'b0;
  initial
  begin
    sclk = 1'b0;
    csn = 1'b1;
  end
  // Released line shows the inverse of the last bit
  always_comb sdio_i = sdio_oe ? sdio_o : (hdrv ? hbit : ~hbit);
  task automatic half();
    repeat (8) @(negedge clock);
  endtask
  // One frame: instruction then nb bytes, first byte in wd[15:8]
  task automatic xfer(input logic rd, input logic [14:0] addr, input int nb, input logic lsb,
    input logic fw, input logic [15:0] wd, output logic [15:0] rdat, output logic [1:0] oe);
    logic [39:0] sh;
    int p;
    sh = {rd, addr, wd, 8'h00};
    rdat = 16'h0000;
    oe = 2'b00;
    csn = 1'b0;
    half();
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      sclk = 1'b0;
      if (i < 16)
        p = 24 + (lsb ? i : 15 - i);
      else
        p = 16 - 8 * ((i - 16) / 8) + (lsb ? i % 8 : 7 - i % 8);
      hdrv = !(rd && i >= 16 && !fw);
      if (hdrv)
        hbit = sh[p];
      half();
      sclk = 1'b1;
      if (i >= 16)
        rdat[p - 8] = fw ? (serial_data_out_oe ? serial_data_out : ~serial_data_out) : sdio_i;
      oe = {sdio_oe, serial_data_out_oe};
      half();
    end
    sclk = 1'b0;
    half();
    csn = 1'b1;
    hdrv = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "dcrb_params.svh"
module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic boot_busy = 1'b0;
  logic boot_done = 1'b0;
  logic boot_timeout = 1'b0;
  logic [7:0] boot_sum = 8'h00;
  logic [7:0] boot_sum_stored = 8'h00;
  logic sclk, csn, sdio_i, sdio_o, sdio_oe, sdout, sdout_oe, soft_reset, spe, core_reset, load_fire;
  logic [2:0] icd;
  logic [1:0] rcd;
  logic [7:0] apin, sync, mix, d;
  logic [183:0] coef;
  logic [15:0] rb;
  logic [1:0] oe;
  logic lsb = 1'b0;
  logic fw = 1'b0;
  int err_count = 0;
  int check_count = 0;
  int fire_count = 0;
  int seed = 89533;
  logic [14:0] ta [9] = '{15'h0000, 15'h0010, 15'h0028, 15'h0029, 15'h002a, 15'h002b, 15'h002c, 15'h002d,
    15'h0006};
  logic [7:0] te [9] = '{8'h00, 8'h00, 8'h00, 8'h2d, 8'h18, 8'h02, 8'h01, 8'h00, {4'h0, `DCRB_REV_ID}};
  logic [7:0] wv [9];
  dcrb_bank dut (.clock(clock), .rstn(rstn), .sclk(sclk), .csn(csn), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .serial_data_out(sdout), .serial_data_out_oe(sdout_oe), .boot_busy(boot_busy),
    .boot_done(boot_done), .boot_timeout(boot_timeout), .boot_sum(boot_sum), .boot_sum_stored(boot_sum_stored),
    .soft_reset(soft_reset), .input_clock_divider(icd), .ref_clock_divider(rcd), .analog_pin_cfg(apin),
    .sync_cfg(sync), .mixer_cfg(mix), .serial_out_pin_enable(spe), .core_reset(core_reset),
    .coef_load_fire(load_fire), .active_coef(coef));
  dcrb_host host (.clock(clock), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_data_out(sdout),
    .serial_data_out_oe(sdout_oe), .sclk(sclk), .csn(csn), .sdio_i(sdio_i));
  always #2.5 clock = ~clock;
  // Load strobe counted mid-cycle, where it is settled
  always @(negedge clock)
    if (load_fire === 1'b1)
      fire_count <= fire_count + 1;
  function automatic logic [7:0] msk(input logic [14:0] a);
    case (a)
      15'h0028: return `DCRB_MSK_APIN;
      15'h0029: return `DCRB_MSK_SYNC;
      15'h002a: return `DCRB_MSK_MIX;
      15'h002b: return `DCRB_MSK_CLK;
      default: return `DCRB_MSK_ONE;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    host.xfer(1'b0, a, 1, lsb, fw, {v, 8'h00}, rb, oe);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 1, lsb, fw, 16'h0000, rb, oe);
    chk(rb[15:8], e);
  endtask
  task automatic boot(input logic to, input logic [7:0] s, input logic [7:0] st);
    @(negedge clock);
    boot_timeout = to;
    boot_sum = s;
    boot_sum_stored = st;
    boot_done = 1'b1;
    @(negedge clock);
    boot_done = 1'b0;
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    repeat (8) @(negedge clock);
    for (int k = 0; k < 9; k++)
      rd(ta[k], te[k]);
    chk(oe, 2'b10);
    for (int k = 2; k < 8; k++)
    begin
      d = 8'($random(seed));
      wv[k] = d & msk(ta[k]);
      wr(ta[k], d);
      rd(ta[k], wv[k]);
    end
    chk({apin, sync, mix, spe, core_reset}, {wv[2], wv[3], wv[4], wv[6][0], wv[7][0]});
    chk({icd, rcd}, {wv[5][4:2], wv[5][1:0]});
    wr(15'h0006, 8'hff);
    wr(15'h002e, 8'hff);
    wr(15'h002f, 8'hff);
    wr(15'h0005, 8'hff);
    rd(15'h0006, te[8]);
    rd(15'h002e, 8'h00);
    rd(15'h002f, 8'h00);
    rd(15'h0005, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      d = 8'($random(seed));
      boot(k == 2, d, k == 0 ? d : ~d);
      rd(15'h002e, d);
      host.xfer(1'b1, 15'h002f, 1, lsb, fw, 16'h0000, rb, oe);
      chk(rb[15:8], k == 0 ? 8'h03 : (k == 1 ? 8'h05 : 8'h04));
      chk(rb[8], k < 2);
    end
    // Serial port is shut while a boot load runs
    boot_busy = 1'b1;
    wr(15'h0028, ~wv[2]);
    boot_busy = 1'b0;
    chk(apin, wv[2]);
    d = 8'($random(seed));
    wr(15'h0011, d);
    chk(coef[183:176], 8'h00);
    wr(15'h0010, 8'h01);
    chk({fire_count[7:0], coef[183:176]}, {8'd1, d});
    wr(15'h0010, 8'h03);
    wr(15'h0010, 8'hfc);
    rd(15'h0010, 8'h00);
    wr(15'h0010, 8'h02);
    chk(fire_count, 2);
    wr(15'h0000, 8'h81);
    chk({soft_reset, sync, icd, rcd}, {1'b1, 8'h2d, 5'h02});
    wr(15'h002b, 8'h1f);
    repeat (200) @(negedge clock);
    rd(15'h002b, 8'h02);
    rd(15'h0000, 8'h81);
    chk({soft_reset, spe, coef[183:176]}, {2'b11, d});
    wr(15'h0000, 8'h00);
    chk(soft_reset, 1'b0);
    wr(15'h0000, 8'h66);
    lsb = 1'b1;
    host.xfer(1'b0, 15'h0028, 2, lsb, fw, 16'h0115, rb, oe);
    chk({apin, sync}, 16'h0115);
    rd(15'h0000, 8'h66);
    wr(15'h0000, 8'h00);
    lsb = 1'b0;
    host.xfer(1'b0, 15'h002a, 2, lsb, fw, 16'h0a3c, rb, oe);
    chk({mix, sync}, 16'h0a3c);
    wr(15'h0000, 8'h10);
    fw = 1'b1;
    rd(15'h0000, 8'h18);
    chk(oe, 2'b01);
    wr(15'h0000, 8'h00);
    fw = 1'b0;
    rd(15'h002a, 8'h0a);
    end_sim();
  end
endmodule
`default_nettype wire
